/* File: shared/fcs_pkg.sv */
// Shared constants and types for the FIR stream channel control block
`default_nettype none
package fcs_pkg;
   // Framing modes of the input last marker
   typedef enum logic [1:0] {FRAME_NONE, FRAME_VECTOR, FRAME_PACKET} fcs_frame_t;
   // Register port
   localparam int ADDR_W = 4;
   localparam int REG_W = 32;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_COUNT = 4'h8;
   // Control register fields and reset values
   localparam int CTRL_PKT_SYNC = 0;
   localparam logic CTRL_PKT_SYNC_RST = 1'b0;
   // Status register fields
   localparam int ST_SET_LSB = 0;
   localparam int ST_SET_W = 8;
   localparam int ST_PEND_LSB = 8;
   localparam int ST_PEND_W = 8;
   localparam int ST_SEEN = 16;
   localparam int ST_PRIMED = 17;
   // Sizes
   localparam int COUNT_W = 16;
   localparam int DEF_FIFO_DEPTH = 16;
   localparam int MAX_USER_W = 256;
   localparam int MAX_SLOTS = 256;
   localparam int RST_MIN_CYC = 2;
endpackage
`default_nettype wire

/* File: shared/fcs_stream_if.sv */
// Valid/ready stream carrier between the block's own modules
`timescale 1ns/100ps
`default_nettype none
interface fcs_stream_if #(
   parameter int W = 8
);
   logic valid; // Word on offer
   logic ready; // Receiver takes it
   logic [W-1:0] data; // Payload
   // Sending end
   modport tx (output valid, output data, input ready);
   // Receiving end
   modport rx (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: src/fcs_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module fcs_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Filling side
   fcs_stream_if.rx wr,
   // Draining side
   fcs_stream_if.tx rd
);
   localparam int PTR_W = DEPTH > 1 ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [W-1:0] mem_q [DEPTH]; // Storage words
   logic [PTR_W-1:0] wptr_q; // Next slot to write
   logic [PTR_W-1:0] rptr_q; // Oldest word
   logic [CNT_W-1:0] cnt_q; // Words held
   logic push;
   logic pop;

   // Full and empty come straight from the count, never guessed
   assign wr.ready = cnt_q != FULL_CNT;
   assign rd.valid = cnt_q != '0;
   assign rd.data = mem_q[rptr_q];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;

   // Storage write, no reset needed on payload
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wptr_q] <= wr.data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge mclk) begin
      if (rst) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wptr_q <= (wptr_q == LAST_PTR) ? '0 : wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_q <= (rptr_q == LAST_PTR) ? '0 : rptr_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/fcs_channel_ctrl.sv */
// Channel control of a streaming FIR filter: framing, config, reload
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module fcs_channel_ctrl #(
   parameter int NUM_CHAN = 4,
   parameter int DATA_W = 16,
   parameter int COEF_W = 16,
   parameter int USER_W = 8,
   parameter int NUM_SETS = 4,
   parameter int NUM_SLOTS = 1,
   parameter int LAT = 4,
   parameter fcs_pkg::fcs_frame_t FRAME = fcs_pkg::FRAME_VECTOR,
   parameter bit HAS_USER = 1'b1,
   parameter bit HAS_CHAN_ID = 1'b1,
   parameter bit HAS_OUT_READY = 1'b1,
   parameter bit HAS_FIFO = 1'b1,
   parameter int FIFO_DEPTH = fcs_pkg::DEF_FIFO_DEPTH,
   parameter bit HAS_CE = 1'b1,
   parameter bit RESET_DATA = 1'b1,
   parameter bit PER_CHANNEL = 1'b0,
   parameter int CHAN_W = NUM_CHAN > 1 ? $clog2(NUM_CHAN) : 1,
   parameter int SET_W = NUM_SETS > 1 ? $clog2(NUM_SETS) : 1
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Input sample stream, user = {channel_index_field, user}
   input wire logic s_valid,
   output logic s_ready,
   input wire logic [DATA_W-1:0] s_data,
   input wire logic s_last,
   input wire logic [USER_W+CHAN_W-1:0] s_user,
   // Output stream, user = {data_valid, channel_index_field, user}
   output logic m_valid,
   input wire logic m_ready,
   output logic [DATA_W+COEF_W-1:0] m_data,
   output logic m_last,
   output logic [USER_W+CHAN_W:0] m_user,
   // Configuration packets
   input wire logic cfg_valid,
   output logic cfg_ready,
   input wire logic [NUM_CHAN*SET_W-1:0] cfg_data,
   // Coefficient reload, data = {set, coefficient}
   input wire logic rld_valid,
   output logic rld_ready,
   input wire logic [SET_W+COEF_W-1:0] rld_data,
   // Framing error pulses in vector framing
   output logic evt_last_missing,
   output logic evt_last_early,
   // Register port
   input wire logic [fcs_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [fcs_pkg::REG_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [fcs_pkg::REG_W-1:0] reg_rdata
);
   localparam int OUT_W = DATA_W + COEF_W;
   localparam int UIN_W = USER_W + CHAN_W;
   localparam int BUF_W = 1 + UIN_W + DATA_W;
   localparam int BUF_D = FIFO_DEPTH > NUM_CHAN ? FIFO_DEPTH : NUM_CHAN;
   localparam int RC_W = $clog2(NUM_SLOTS + 1);
   localparam logic [CHAN_W-1:0] LAST_CHAN = CHAN_W'(NUM_CHAN - 1);
   localparam logic [RC_W-1:0] SLOTS_FULL = RC_W'(NUM_SLOTS);
   localparam logic [CHAN_W:0] PRIME_CNT = (CHAN_W+1)'(NUM_CHAN);
   localparam logic [COEF_W-1:0] COEF_RST = COEF_W'(1);

   // Enable, stall and processing terms
   logic ce_eff; // Effective clock enable
   logic out_hold; // Output word waits for downstream
   logic adv; // Pipeline moves this cycle
   logic proc; // A sample enters the datapath
   logic consume; // A config packet is taken
   logic b_valid; // Buffered sample on offer
   logic [BUF_W-1:0] b_word; // Buffered {last, user, data}
   logic b_last; // Buffered last, framing applied
   logic [UIN_W-1:0] b_user;
   logic [DATA_W-1:0] b_data;
   // Control state
   logic [CHAN_W-1:0] chan_q; // Channel of next sample
   logic seen_last_q; // Last marker received since consume
   logic pkt_sync_q; // Packet synchronisation enabled
   logic [CHAN_W:0] prime_q; // Samples since reset, saturating
   logic [SET_W-1:0] active_q [NUM_CHAN]; // Active set per channel
   logic [SET_W-1:0] sel_set; // Set used for this sample
   logic [COEF_W-1:0] coef_q [NUM_SETS]; // Coefficients in use
   logic [SET_W-1:0] slot_set_q [NUM_SLOTS]; // Pending reloads
   logic [COEF_W-1:0] slot_coef_q [NUM_SLOTS];
   logic [RC_W-1:0] rcnt_q; // Pending reload count
   logic [fcs_pkg::COUNT_W-1:0] count_q; // Samples processed
   // Pipeline
   logic [LAT-1:0] pv_q; // Stage holds a sample
   logic [LAT-1:0] pl_q; // Last marker per stage
   logic [LAT-1:0] pok_q; // Meaningful-output flag per stage
   logic [OUT_W-1:0] pd_q [LAT];
   logic [UIN_W-1:0] pu_q [LAT];
   logic [CHAN_W-1:0] pc_q [LAT];

   fcs_stream_if #(.W(BUF_W)) in_if ();
   fcs_stream_if #(.W(BUF_W)) buf_if ();

   // Without the port the enable is taken as high
   assign ce_eff = !HAS_CE || ce;

   // Gating the input handshake keeps the buffer still
   assign in_if.valid = s_valid && ce_eff;
   assign in_if.data = {s_last, s_user, s_data};
   assign s_ready = in_if.ready && ce_eff;

   // Input buffer deep enough for a whole vector
   generate
      if (HAS_FIFO) begin : g_fifo
         fcs_fifo #(
            .W(BUF_W),
            .DEPTH(BUF_D)
         ) u_fifo (
            .mclk(mclk),
            .rst(rst),
            .wr(in_if),
            .rd(buf_if)
         );
      end else begin : g_direct
         assign buf_if.valid = in_if.valid;
         assign buf_if.data = in_if.data;
         assign in_if.ready = buf_if.ready;
      end
   endgenerate

   assign b_valid = buf_if.valid;
   assign b_word = buf_if.data;
   assign b_data = b_word[DATA_W-1:0];
   assign b_user = b_word[DATA_W +: UIN_W];
   // Marker dropped when framing is off
   assign b_last = (FRAME != fcs_pkg::FRAME_NONE) && b_word[BUF_W-1];

   // Stall the whole pipeline while the output word waits
   assign out_hold = HAS_OUT_READY && pv_q[LAT-1] && !m_ready;
   assign adv = ce_eff && !out_hold;
   assign buf_if.ready = adv;
   assign proc = adv && b_valid;

   // Consume on a vector's first sample, or every sample for one channel
   // packet mode also waits for a last
   assign consume = proc && cfg_valid
      && (NUM_CHAN == 1 || chan_q == '0)
      && (!pkt_sync_q || seen_last_q);
   assign cfg_ready = consume;

   // A new packet applies to the very sample that consumes it
   always_comb begin
      sel_set = active_q[chan_q];
      if (consume) begin
         // One set for all channels, or a slice per channel
         sel_set = PER_CHANNEL ? cfg_data[chan_q*SET_W +: SET_W]
                               : cfg_data[SET_W-1:0];
      end
   end

   // Channel counter, resynchronised by the marker in vector framing
   always_ff @(posedge mclk) begin
      if (rst) begin
         chan_q <= '0;
      end else if (proc) begin
         if (FRAME == fcs_pkg::FRAME_VECTOR && b_last) begin
            chan_q <= '0;
         end else if (chan_q == LAST_CHAN) begin
            chan_q <= '0;
         end else begin
            chan_q <= chan_q + 1'b1;
         end
      end
   end

   // Framing checks: upstream must mark the final channel
   always_ff @(posedge mclk) begin
      if (rst) begin
         evt_last_missing <= 1'b0;
         evt_last_early <= 1'b0;
      end else if (ce_eff) begin
         evt_last_missing <= FRAME == fcs_pkg::FRAME_VECTOR && proc
            && chan_q == LAST_CHAN && !b_last;
         evt_last_early <= FRAME == fcs_pkg::FRAME_VECTOR && proc
            && chan_q != LAST_CHAN && b_last;
      end
   end

   // Marker seen at the input port; a new one beats the clearing consume
   always_ff @(posedge mclk) begin
      if (rst) begin
         seen_last_q <= 1'b0;
      end else if (s_valid && s_ready && s_last
                   && FRAME != fcs_pkg::FRAME_NONE) begin
         seen_last_q <= 1'b1;
      end else if (consume) begin
         seen_last_q <= 1'b0;
      end
   end

   // Active set per channel
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            active_q[i] <= '0;
         end
      end else if (consume) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            active_q[i] <= PER_CHANNEL ? cfg_data[i*SET_W +: SET_W]
                                       : cfg_data[SET_W-1:0];
         end
      end
   end

   // Reload slots fill ahead; nothing reaches use until a consume
   assign rld_ready = ce_eff && (consume || rcnt_q != SLOTS_FULL);

   always_ff @(posedge mclk) begin
      if (rst) begin
         rcnt_q <= '0;
      end else if (ce_eff) begin
         // Commit empties the slots; a same-cycle reload takes slot 0
         rcnt_q <= (consume ? '0 : rcnt_q)
            + RC_W'(rld_valid && rld_ready);
      end
   end

   // Slot storage, no reset needed
   always_ff @(posedge mclk) begin
      if (rld_valid && rld_ready) begin
         slot_set_q[consume ? '0 : rcnt_q] <= rld_data[COEF_W +: SET_W];
         slot_coef_q[consume ? '0 : rcnt_q] <= rld_data[COEF_W-1:0];
      end
   end

   // Coefficients in use; pending slots land in order on consume
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < NUM_SETS; i++) begin
            coef_q[i] <= COEF_RST;
         end
      end else if (consume) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            if (RC_W'(i) < rcnt_q) begin
               coef_q[slot_set_q[i]] <= slot_coef_q[i];
            end
         end
      end
   end

   // Count of samples since reset, for the output-valid flag
   always_ff @(posedge mclk) begin
      if (rst) begin
         prime_q <= '0;
      end else if (proc && prime_q != PRIME_CNT) begin
         prime_q <= prime_q + 1'b1;
      end
   end

   // Pipeline control bits are always cleared by reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         pv_q <= '0;
         pl_q <= '0;
         pok_q <= '0;
      end else if (adv) begin
         pv_q <= {pv_q[LAT-2:0], b_valid};
         // Marker rides with its sample, same latency
         pl_q <= {pl_q[LAT-2:0], b_last};
         // Each channel needs one sample since reset
         pok_q <= {pok_q[LAT-2:0], prime_q != '0
                   && (prime_q == PRIME_CNT || chan_q < prime_q[CHAN_W-1:0])};
      end
   end

   // Data vector, cleared by reset only when chosen
   always_ff @(posedge mclk) begin
      if (rst && RESET_DATA) begin
         for (int i = 0; i < LAT; i++) begin
            pd_q[i] <= '0;
            pu_q[i] <= '0;
            pc_q[i] <= '0;
         end
      end else if (adv) begin
         // Stand-in product of sample and the selected coefficient
         pd_q[0] <= OUT_W'(b_data) * OUT_W'(coef_q[sel_set]);
         pu_q[0] <= b_user;
         pc_q[0] <= chan_q;
         for (int i = 1; i < LAT; i++) begin
            pd_q[i] <= pd_q[i-1];
            pu_q[i] <= pu_q[i-1];
            pc_q[i] <= pc_q[i-1];
         end
      end
   end

   // Output stream from the last stage
   assign m_valid = pv_q[LAT-1];
   assign m_data = pd_q[LAT-1];
   assign m_last = (FRAME != fcs_pkg::FRAME_NONE) && pl_q[LAT-1];
   // Output user fields exist only when chosen
   assign m_user[USER_W-1:0] = HAS_USER ? pu_q[LAT-1][USER_W-1:0]
                                        : '0;
   assign m_user[USER_W +: CHAN_W] = HAS_CHAN_ID ? pc_q[LAT-1] : '0;
   // Valid flag only when the data vector is not reset
   assign m_user[UIN_W] = !RESET_DATA && pok_q[LAT-1];

   // Control register write
   always_ff @(posedge mclk) begin
      if (rst) begin
         pkt_sync_q <= fcs_pkg::CTRL_PKT_SYNC_RST;
      end else if (reg_wr && reg_addr == fcs_pkg::REG_CTRL) begin
         pkt_sync_q <= reg_wdata[fcs_pkg::CTRL_PKT_SYNC];
      end
   end

   // Processed-sample counter, wraps
   always_ff @(posedge mclk) begin
      if (rst) begin
         count_q <= '0;
      end else if (proc) begin
         count_q <= count_q + 1'b1;
      end
   end

   // Read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               fcs_pkg::REG_CTRL: begin
                  reg_rdata[fcs_pkg::CTRL_PKT_SYNC] <= pkt_sync_q;
               end
               fcs_pkg::REG_STATUS: begin
                  reg_rdata[fcs_pkg::ST_SET_LSB +: fcs_pkg::ST_SET_W]
                     <= fcs_pkg::ST_SET_W'(active_q[0]);
                  reg_rdata[fcs_pkg::ST_PEND_LSB +: fcs_pkg::ST_PEND_W]
                     <= fcs_pkg::ST_PEND_W'(rcnt_q);
                  reg_rdata[fcs_pkg::ST_SEEN] <= seen_last_q;
                  reg_rdata[fcs_pkg::ST_PRIMED] <= prime_q == PRIME_CNT;
               end
               fcs_pkg::REG_COUNT: begin
                  reg_rdata[fcs_pkg::COUNT_W-1:0] <= count_q;
               end
               default: begin
                  reg_rdata <= '0;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: testbench/fcs_ctrl_monitor.sv */
// Concurrent checks on the ports of the FIR stream channel control block
`timescale 1ns/100ps
`default_nettype none
module fcs_ctrl_monitor #(
   parameter int DATA_W = 16,
   parameter int COEF_W = 16,
   parameter int USER_W = 8,
   parameter int CHAN_W = 2
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Data streams
   input wire logic s_ready,
   input wire logic m_valid,
   input wire logic m_ready,
   input wire logic [DATA_W+COEF_W-1:0] m_data,
   input wire logic m_last,
   input wire logic [USER_W+CHAN_W:0] m_user,
   // Config, reload, events
   input wire logic cfg_valid,
   input wire logic cfg_ready,
   input wire logic rld_ready,
   input wire logic evt_last_missing
);
   // Single clock domain, so one default clock and disable
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   chk_out_hold: assert property (m_valid && !m_ready |=> m_valid
      && $stable(m_data) && $stable(m_user) && $stable(m_last))
      else $error("output word moved under stall");
   chk_ce_gate: assert property (!ce |->
      !s_ready && !cfg_ready && !rld_ready)
      else $error("handshake open while enable low");
   chk_ce_freeze: assert property (!ce |=>
      $stable(m_valid) && $stable(m_data) && $stable(m_user))
      else $error("output moved while enable low");
   chk_cfg_gate: assert property (cfg_ready |-> cfg_valid && ce)
      else $error("config consumed with none offered");
   // Four channels, so a consume repeats on the next sample only after a last on channel 0
   chk_cfg_once: assert property (cfg_ready |=> !cfg_ready)
      else $error("config consumed twice in a vector");
   chk_dv_flag: assert property (m_user[USER_W+CHAN_W] == 1'b0)
      else $error("valid flag present with data reset");
   chk_miss_pulse: assert property (evt_last_missing |=>
      !evt_last_missing)
      else $error("missing-last event longer than a cycle");
   chk_reset_quiet: assert property ($past(rst) |->
      !m_valid && !cfg_ready && !m_last)
      else $error("output active right after reset");
   // Main scenarios reached
   cover property (cfg_ready);
   cover property (m_valid && !m_ready);
   cover property (!ce && m_valid);
endmodule
`default_nettype wire

/* File: testbench/fcs_sink_model.sv */
// Downstream sink model that grants or withholds output ready
`timescale 1ns/100ps
`default_nettype none
module fcs_sink_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Stall pattern: 0 never, 1 every other cycle, 2 always
   input wire logic [1:0] mode,
   // Ready towards the block
   output logic m_ready
);
   logic tog_q; // Alternation phase
   // Phase flips each cycle so mode 1 takes half the words
   always @(posedge mclk) begin
      tog_q <= rst ? 1'b0 : !tog_q;
   end
   // Ready moves only just after an edge, as real logic would
   always @(posedge mclk) begin
      // Held low in reset so a single process drives it
      m_ready <= !rst && ((mode == 2'h0) || (mode == 2'h1 && tog_q));
   end
endmodule
`default_nettype wire

/* File: testbench/fir_stream_channel_control_tb_top.sv */
// Self-checking testbench of the FIR stream channel control block
`timescale 1ns/100ps
`default_nettype none
module fir_stream_channel_control_tb_top;
   logic mclk, rst = 1, ce = 1; // Clock, reset, enable
   logic s_valid = 0, s_last = 0, s_ready; // Input stream
   logic [15:0] s_data = '0;
   logic [9:0] s_user = '0;
   logic m_valid, m_ready, m_last; // Output stream
   logic [31:0] m_data;
   logic [10:0] m_user;
   logic cfg_valid = 0, cfg_ready, rld_valid = 0, rld_ready; // Control
   logic [7:0] cfg_data = '0;
   logic [17:0] rld_data = '0;
   logic evt_m, evt_e; // Framing events
   logic [3:0] reg_addr = '0; // Register port
   logic [31:0] reg_wdata = '0, reg_rdata;
   logic reg_wr = 0, reg_rd = 0;
   logic [1:0] mode = 2'h1; // Sink stall pattern
   int errors = 0, num_checks = 0, n_cfg = 0, n_miss = 0, n_early = 0;
   logic [42:0] exp_q[$]; // Expected {last, chan, user, data}
   logic [1:0] ch = '0; // Expected channel of the next sample
   logic [15:0] cur_coef = 16'h0001; // Coefficient in force
   fcs_channel_ctrl u_dut (.mclk(mclk), .rst(rst), .ce(ce),
      .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
      .s_last(s_last), .s_user(s_user), .m_valid(m_valid),
      .m_ready(m_ready), .m_data(m_data), .m_last(m_last),
      .m_user(m_user), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
      .cfg_data(cfg_data), .rld_valid(rld_valid),
      .rld_ready(rld_ready), .rld_data(rld_data),
      .evt_last_missing(evt_m), .evt_last_early(evt_e),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   fcs_sink_model u_sink (.mclk(mclk), .rst(rst), .mode(mode),
      .m_ready(m_ready));
   // Free-running clock, 100 ns period
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] expv,
         input string msg);
      num_checks++;
      if (got !== expv) begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, expv);
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Scoreboard on accepted words, plus event counters
   always @(posedge mclk) begin
      if (!rst && m_valid && m_ready) begin
         if (exp_q.size() == 0) chk(1, 0, "extra word");
         else chk({m_last, m_user[9:0], m_data}, exp_q.pop_front(),
            "output word");
      end
      if (!rst && cfg_ready) n_cfg++;
      if (!rst && evt_m) n_miss++;
      if (!rst && evt_e) n_early++;
   end
   task automatic reg_put(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic reg_get(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      d = reg_rdata;
   endtask
   // Offer one sample and hold it until taken; w counts refused edges
   task automatic send(input logic [15:0] d, input logic l, output int w);
      logic [31:0] p;
      p = {16'h0000, d} * {16'h0000, cur_coef};
      exp_q.push_back({l, ch, d[7:0], p});
      ch = l ? 2'h0 : ch + 2'h1;
      s_valid <= 1'b1;
      s_data <= d;
      s_user <= {2'h0, d[7:0]};
      s_last <= l;
      w = 0;
      @(posedge mclk);
      while (!s_ready && w < 100) begin
         w++;
         @(posedge mclk);
      end
      if (w == 100) chk(w, 0, "sample not taken");
   endtask
   // One vector of four channels, last on channel 3 if asked
   task automatic vec(input logic [15:0] b, input logic l);
      int w;
      for (int i = 0; i < 4; i++) send(b + 16'(i), l && i == 3, w);
      s_valid <= 1'b0;
   endtask
   task automatic drain;
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 300) begin
         n++;
         @(posedge mclk);
      end
      chk(exp_q.size(), 0, "words left");
   endtask
   // Reset values, unmapped write ignored
   task automatic t_regs;
      logic [31:0] d;
      reg_put(4'hC, 32'hFFFFFFFF);
      for (int a = 0; a < 16; a += 4) begin
         reg_get(4'(a), d);
         chk(d, 0, "reset value");
      end
   endtask
   // Reload waits for a config packet, which also selects the set
   task automatic t_reload;
      logic [31:0] d;
      int w;
      rld_valid <= 1'b1;
      rld_data <= {2'h2, 16'h0003};
      @(posedge mclk);
      while (!rld_ready) @(posedge mclk);
      rld_valid <= 1'b0;
      vec(16'h0010, 1'b1);
      drain;
      reg_get(4'h4, d);
      chk(d[15:8], 1, "pending reload");
      cfg_valid <= 1'b1;
      cfg_data <= 8'hF2; // Upper fields unused by the single method
      // Commit lands after the consuming sample, which keeps the old value
      send(16'h0020, 1'b0, w);
      cur_coef = 16'h0003;
      for (int i = 1; i < 4; i++) send(16'h0020 + 16'(i), i == 3, w);
      s_valid <= 1'b0;
      cfg_valid <= 1'b0;
      drain;
      reg_get(4'h4, d);
      chk(d[15:0], 16'h0002, "active set");
   endtask
   // Config held on offer over three vectors, first one without last
   task automatic t_sync(input logic ps, input int expc);
      mode <= 2'h0; // No stalls, so intake and processing stay in step
      reg_put(4'h0, {31'h0, ps});
      n_cfg = 0;
      n_miss = 0;
      cfg_valid <= 1'b1;
      cfg_data <= 8'h02;
      vec(16'h0100, 1'b0);
      vec(16'h0200, 1'b1);
      vec(16'h0300, 1'b1);
      drain;
      cfg_valid <= 1'b0;
      chk(n_cfg, expc, "config consumes");
      chk(n_miss, 1, "missing last");
   endtask
   // Sink stalls: twenty taken at once (first sixteen checked), then refusal, then drain
   task automatic t_burst;
      int w, ws, wt;
      ws = 0;
      wt = 0;
      n_early = 0;
      mode <= 2'h2;
      fork
         begin
            repeat (40) @(posedge mclk);
            mode <= 2'h0;
         end
      join_none
      for (int i = 0; i < 24; i++) begin
         // Lasts on words 21 and 23 arrive early, on channel 1
         send(16'h0400 + 16'(i), i % 4 == 3 || i == 21, w);
         if (i < 16) ws += w;
         wt += w;
      end
      s_valid <= 1'b0;
      chk(ws, 0, "burst refused");
      chk(wt > 0, 1, "no back-pressure");
      drain;
      chk(n_early, 2, "early last");
   endtask
   // Enable low closes handshakes; register port keeps working
   task automatic t_ce;
      logic [31:0] d;
      mode <= 2'h2;
      vec(16'h0500, 1'b1);
      repeat (10) @(posedge mclk);
      ce <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({s_ready, cfg_ready, rld_ready}, 0, "enable low");
      reg_get(4'h4, d);
      chk(d[7:0], 8'h02, "status under enable low");
      ce <= 1'b1;
      mode <= 2'h0;
      drain;
   endtask
   // Main sequence: reset held three cycles, then every scenario
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_regs;
      t_reload;
      t_sync(1'b0, 3);
      t_sync(1'b1, 2);
      t_burst;
      t_ce;
      test_done;
   end
   // Watchdog well beyond the expected run of under 1000 cycles
   initial begin
      repeat (5000) @(posedge mclk);
      errors++;
      test_done;
   end
endmodule
bind fcs_channel_ctrl fcs_ctrl_monitor #(.DATA_W(DATA_W), .COEF_W(COEF_W),
   .USER_W(USER_W), .CHAN_W(CHAN_W)) u_mon (.mclk(mclk), .rst(rst),
   .ce(ce), .s_ready(s_ready), .m_valid(m_valid), .m_ready(m_ready),
   .m_data(m_data), .m_last(m_last), .m_user(m_user),
   .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .rld_ready(rld_ready),
   .evt_last_missing(evt_last_missing));
`default_nettype wire
